/* File: hdl/pom_top.sv */
// Purpose: Output priority mux for ports 1 to 3 plus port H snapshot
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Pin outputs registered, so they follow enables by one cycle
// Overview of operation
// (R1) Open-drain bit makes port 2 pin drive low
// (R2) Open-drain register 8 bits, RW, resets zero
// (R3) Snapshot captures port H on trigger, read-only
// (R4) Two sense bits choose level or edge trigger
// (R5) Peripheral output enable high means peripheral owns pin
// (R6) Plain pins: direction bit picks output or input
// (R7) Port 1 bit 6 serial clock beats direction
// (R8) Port 1 bit 4 serial transmit beats direction
// (R9) Timer enables on port 2 beat direction
// (R10) Port 2 bit 1: select, timer, direction
// (R11) Port 3: timer, pattern generator, then direction
// (R12) Location register picks A or B pin
// (R13) Direction bits write-only, reset to input
// (R14) After reset all pins are inputs, undriven
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module pom_top
  import pom_pkg::*;
(
  input wire logic clk,                     // System clock, 10 MHz
  input wire logic nrst,                    // Synchronous reset, active low
  input wire logic [3:0] reg_addr,          // Register index
  input wire logic [7:0] reg_wdata,         // Write data
  input wire logic reg_wr,                  // Write strobe
  input wire logic reg_rd,                  // Read strobe
  output logic [7:0] reg_rdata,             // Read data, cycle after strobe
  input wire logic serial_clock_out_en,     // Serial clock enable, port 1 bit 6
  input wire logic serial_clock_out,        // Serial clock level
  input wire logic serial_tx_out_en,        // Serial transmit enable, port 1 bit 4
  input wire logic serial_tx_out,           // Serial transmit level
  input wire logic sync_serial_select_out_en, // Sync serial select enable
  input wire logic sync_serial_select_out,  // Sync serial select level
  input wire logic [7:0] timer2_out_en,     // Timer enables for port 2 pins
  input wire logic [7:0] timer2_out,        // Timer levels for port 2 pins
  input wire logic [7:0] timer3_out_en,     // Timer enables for port 3 pins
  input wire logic [7:0] timer3_out,        // Timer levels for port 3 pins
  input wire logic [7:0] pattern_out_en,    // Pattern generator enables, port 3
  input wire logic [7:0] pattern_out,       // Pattern generator levels, port 3
  input wire logic [7:0] port1_in,          // Port 1 pin levels
  input wire logic [7:0] port2_in,          // Port 2 pin levels
  input wire logic [7:0] port3_in,          // Port 3 pin levels
  input wire logic [7:0] port_h_in,         // Port H pin levels
  input wire logic snapshot_trigger_pin,    // Trigger pin, low level or edge chosen by sense bits
  output logic [7:0] port1_out,             // Port 1 driven level
  output logic [7:0] port1_oe,              // Port 1 driver enable
  output logic [7:0] port2_out,             // Port 2 driven level
  output logic [7:0] port2_oe,              // Port 2 driver enable
  output logic [7:0] port3_out,             // Port 3 driven level
  output logic [7:0] port3_oe,              // Port 3 driver enable
  output logic [7:0] port_h_out,            // Port H driven level
  output logic [7:0] port_h_oe,             // Port H driver enable
  output logic pin_location_b               // Alternate location select to peripherals
);
  typedef struct packed {
    logic [7:0] dir1;
    logic [7:0] dir2;
    logic [7:0] dir3;
    logic [7:0] dirh;
    logic [7:0] dat1;
    logic [7:0] dat2;
    logic [7:0] dat3;
    logic [7:0] dath;
    logic [7:0] odsel;
    logic [7:0] snap;
    logic [1:0] sense;
    logic [7:0] locsel;
    logic [7:0] rdata;
    logic [7:0] p1o;
    logic [7:0] p1e;
    logic [7:0] p2o;
    logic [7:0] p2e;
    logic [7:0] p3o;
    logic [7:0] p3e;
    logic [7:0] pho;
    logic [7:0] phe;
  } pom_state_t;

  pom_state_t s_q;
  pom_state_t s_d;
  logic fire;
  logic [7:0] e1;
  logic [7:0] v1;
  logic [7:0] e2;
  logic [7:0] v2;
  logic [7:0] e3;
  logic [7:0] v3;
  logic [2:0] oe1 [8];
  logic [2:0] dt1 [8];
  logic [2:0] oe2 [8];
  logic [2:0] dt2 [8];

  // Register read decode; direction registers return zero as undefined data
  function automatic logic [7:0] rd_mux(input logic [3:0] a, input pom_state_t s,
                                        input logic [7:0] p1, input logic [7:0] p2,
                                        input logic [7:0] p3);
    logic [7:0] r;
    r = POM_UNMAPPED;
    case (a)
      POM_A_P1_DATA: r = s.dat1;
      POM_A_P2_DATA: r = s.dat2;
      POM_A_P3_DATA: r = s.dat3;
      POM_A_PH_DATA: r = s.dath;
      POM_A_ODSEL: r = s.odsel;
      POM_A_SNAP: r = s.snap;
      POM_A_SENSE: r = {6'h00, s.sense};
      POM_A_LOCSEL: r = s.locsel;
      // Pin status shows pin levels for inputs, data bits for outputs
      POM_A_PIN1: r = (s.dat1 & s.dir1) | (p1 & ~s.dir1);
      POM_A_PIN2: r = (s.dat2 & s.dir2) | (p2 & ~s.dir2);
      POM_A_PIN3: r = (s.dat3 & s.dir3) | (p3 & ~s.dir3);
      default: r = POM_UNMAPPED;
    endcase
    return r;
  endfunction

  pom_trig_det u_trig (
    .clk(clk),
    .nrst(nrst),
    .pin(snapshot_trigger_pin),
    .sense(s_q.sense),
    .fire(fire)
  );

  // Per-pin enable sets; unused priority slots are tied low
  always_comb begin
    for (int i = 0; i < POM_W; i++) begin
      oe1[i] = 3'h0;
      dt1[i] = 3'h0;
      oe2[i] = {1'b0, 1'b0, timer2_out_en[i]};
      dt2[i] = {1'b0, 1'b0, timer2_out[i]};
    end
    oe1[POM_P1_CLK_BIT] = {2'h0, serial_clock_out_en}; // see R7
    dt1[POM_P1_CLK_BIT] = {2'h0, serial_clock_out};
    oe1[POM_P1_TX_BIT] = {2'h0, serial_tx_out_en}; // see R8
    dt1[POM_P1_TX_BIT] = {2'h0, serial_tx_out};
    // Select output ahead of the timer on bit 1, see R10
    oe2[POM_P2_SEL_BIT] = {1'b0, timer2_out_en[POM_P2_SEL_BIT], sync_serial_select_out_en};
    dt2[POM_P2_SEL_BIT] = {1'b0, timer2_out[POM_P2_SEL_BIT], sync_serial_select_out};
  end

  // One selector per pin for each of ports 1 to 3
  genvar g;
  generate
    for (g = 0; g < POM_W; g++) begin : g_pin
      pom_pin_sel u_p1 (
        .oe(oe1[g]),
        .dat(dt1[g]),
        .dir(s_q.dir1[g]),
        .port_dat(s_q.dat1[g]),
        .od(1'b0),
        .drv_en(e1[g]),
        .drv_val(v1[g])
      );
      // Timer first on port 2 except bit 1, where select leads, see R9 R10; open drain applies here, see R1
      pom_pin_sel u_p2 (
        .oe(oe2[g]),
        .dat(dt2[g]),
        .dir(s_q.dir2[g]),
        .port_dat(s_q.dat2[g]),
        .od(s_q.odsel[g]),
        .drv_en(e2[g]),
        .drv_val(v2[g])
      );
      // Timer then pattern generator then direction, see R11
      pom_pin_sel u_p3 (
        .oe({1'b0, pattern_out_en[g], timer3_out_en[g]}),
        .dat({1'b0, pattern_out[g], timer3_out[g]}),
        .dir(s_q.dir3[g]),
        .port_dat(s_q.dat3[g]),
        .od(1'b0),
        .drv_en(e3[g]),
        .drv_val(v3[g])
      );
    end
  endgenerate

  // Next-state logic: register writes, snapshot, registered pin drive
  always_comb begin
    s_d = s_q;
    if (reg_wr) begin
      case (reg_addr)
        POM_A_P1_DIR: s_d.dir1 = reg_wdata; // see R13
        POM_A_P2_DIR: s_d.dir2 = reg_wdata; // see R13
        POM_A_P3_DIR: s_d.dir3 = reg_wdata; // see R13
        POM_A_PH_DIR: s_d.dirh = reg_wdata; // see R13
        POM_A_P1_DATA: s_d.dat1 = reg_wdata;
        POM_A_P2_DATA: s_d.dat2 = reg_wdata;
        POM_A_P3_DATA: s_d.dat3 = reg_wdata;
        POM_A_PH_DATA: s_d.dath = reg_wdata;
        POM_A_ODSEL: s_d.odsel = reg_wdata; // see R2
        POM_A_SENSE: s_d.sense = reg_wdata[1:0]; // see R4
        POM_A_LOCSEL: s_d.locsel = reg_wdata; // see R12
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    // Snapshot has no write path at all, see R3
    if (fire) begin
      s_d.snap = port_h_in; // see R3
    end
    // Read data is valid only in the cycle after the strobe
    s_d.rdata = reg_rd ? rd_mux(reg_addr, s_q, port1_in, port2_in, port3_in) : POM_RST8;
    s_d.p1o = v1;
    s_d.p1e = e1;
    s_d.p2o = v2;
    s_d.p2e = e2;
    s_d.p3o = v3;
    s_d.p3e = e3;
    // Port H has no peripheral output, see R6
    s_d.pho = s_q.dath;
    s_d.phe = s_q.dirh;
  end

  // State register; all enables clear so every pin is an input, see R14
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.sense <= POM_RST2;
      s_q.odsel <= POM_RST8; // see R2
      s_q.snap <= POM_RST8;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign port1_out = s_q.p1o;
  assign port1_oe = s_q.p1e;
  assign port2_out = s_q.p2o;
  assign port2_oe = s_q.p2e;
  assign port3_out = s_q.p3o;
  assign port3_oe = s_q.p3e;
  assign port_h_out = s_q.pho;
  assign port_h_oe = s_q.phe;
  // Location bit goes to the peripherals' pin routing, see R12
  assign pin_location_b = s_q.locsel[POM_LOC_SEL_BIT];
endmodule

/* File: common/pom_pkg.sv */
// Purpose: Shared constants for the port output priority mux block
// Assumes: 8-bit register port, one clock, synchronous active-low reset
// Notes: Register indices are the word addresses on the plain register port
package pom_pkg;
  localparam int unsigned POM_W = 8;
  localparam logic [3:0] POM_A_P1_DIR = 4'h0;
  localparam logic [3:0] POM_A_P2_DIR = 4'h1;
  localparam logic [3:0] POM_A_P3_DIR = 4'h2;
  localparam logic [3:0] POM_A_PH_DIR = 4'h3;
  localparam logic [3:0] POM_A_P1_DATA = 4'h4;
  localparam logic [3:0] POM_A_P2_DATA = 4'h5;
  localparam logic [3:0] POM_A_P3_DATA = 4'h6;
  localparam logic [3:0] POM_A_PH_DATA = 4'h7;
  localparam logic [3:0] POM_A_ODSEL = 4'h8;
  localparam logic [3:0] POM_A_SNAP = 4'h9;
  localparam logic [3:0] POM_A_SENSE = 4'hA;
  localparam logic [3:0] POM_A_LOCSEL = 4'hB;
  localparam logic [3:0] POM_A_PIN1 = 4'hC;
  localparam logic [3:0] POM_A_PIN2 = 4'hD;
  localparam logic [3:0] POM_A_PIN3 = 4'hE;
  localparam logic [7:0] POM_RST8 = 8'h00;
  localparam logic [1:0] POM_RST2 = 2'h0;
  localparam logic [7:0] POM_UNMAPPED = 8'h00;
  // Sense codes: {rise, fall}
  localparam logic [1:0] POM_SENSE_LOW = 2'h0;
  localparam logic [1:0] POM_SENSE_FALL = 2'h1;
  localparam logic [1:0] POM_SENSE_RISE = 2'h2;
  localparam logic [1:0] POM_SENSE_BOTH = 2'h3;
  // Bit positions of the serial functions on port 1 and select on port 2
  localparam int unsigned POM_P1_TX_BIT = 4;
  localparam int unsigned POM_P1_CLK_BIT = 6;
  localparam int unsigned POM_P2_SEL_BIT = 1;
  localparam int unsigned POM_LOC_SEL_BIT = 0;
endpackage

/* File: hdl/pom_pin_sel.sv */
// Purpose: One pin's output driver selection by priority
// Assumes: Enables are active high, a lower index wins
// Notes: Combinational; caller registers the results
`timescale 1ns/1ps
module pom_pin_sel
  import pom_pkg::*;
(
  input wire logic [2:0] oe,    // Peripheral enables, bit 0 highest
  input wire logic [2:0] dat,   // Peripheral data per enable
  input wire logic dir,         // Direction bit
  input wire logic port_dat,    // Port data bit
  input wire logic od,          // Open-drain select
  output logic drv_en,          // Pin driver enable
  output logic drv_val          // Pin driven level
);
  logic val;
  logic en;
  // First asserted enable wins, else the direction bit decides, see R5 R6
  always_comb begin
    val = port_dat;
    en = dir;
    if (oe[0]) begin
      val = dat[0];
      en = 1'b1;
    end else if (oe[1]) begin
      val = dat[1];
      en = 1'b1;
    end else if (oe[2]) begin
      val = dat[2];
      en = 1'b1;
    end
    drv_val = val;
    // Open drain releases the pin for a high level, see R1
    drv_en = en & ~(od & val);
  end
endmodule

/* File: hdl/pom_trig_det.sv */
// Purpose: Trigger detector for the snapshot trigger pin
// Assumes: Pin input synchronous to clk
// Notes: Low-level sense fires every cycle the pin stays low
`timescale 1ns/1ps
module pom_trig_det
  import pom_pkg::*;
(
  input wire logic clk,         // System clock
  input wire logic nrst,        // Synchronous reset, active low
  input wire logic pin,         // Trigger pin level
  input wire logic [1:0] sense, // {rise, fall} sense bits
  output logic fire             // Capture strobe, combinational
);
  logic prev_q;
  // Previous level held high after reset so no false rise appears
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin;
    end
  end
  // Sense selection, see R4
  always_comb begin
    case (sense)
      POM_SENSE_LOW: fire = ~pin;
      POM_SENSE_FALL: fire = prev_q & ~pin;
      POM_SENSE_RISE: fire = ~prev_q & pin;
      POM_SENSE_BOTH: fire = prev_q ^ pin;
      default: fire = 1'b0;
    endcase
  end
endmodule

/* File: sim/pom_board.sv */
// Purpose: Board circuitry on one 8-bit port
// Assumes: Pins not driven by the block float
// Notes: Floating pins toggle each cycle so stale values never pass
`timescale 1ns/1ps
module pom_board (
  input wire logic clk,        // System clock
  input wire logic [7:0] drv,  // Level the block drives
  input wire logic [7:0] en,   // Driver enables
  output logic [7:0] lvl       // Level seen on the pins
);
  logic [7:0] flt_q = 8'h55;
  // Undriven pins wander instead of holding a last value
  always @(posedge clk) flt_q <= ~flt_q;
  assign lvl = (en & drv) | (~en & flt_q);
endmodule

/* File: sim/pom_monitor.sv */
// Purpose: Port-level checks for the output priority mux
// Assumes: Pin outputs lag their enables by one clock
// Notes: Bound into pom_top
`timescale 1ns/1ps
module pom_monitor (
  input wire logic clk,                 // Clock
  input wire logic nrst,                // Reset, active low
  input wire logic [3:0] reg_addr,      // Index
  input wire logic reg_rd,              // Read strobe
  input wire logic [7:0] reg_rdata,     // Read data
  input wire logic serial_clock_out_en, // Clock enable
  input wire logic serial_clock_out,    // Clock level
  input wire logic serial_tx_out_en,    // Transmit enable
  input wire logic serial_tx_out,       // Transmit level
  input wire logic sync_serial_select_out_en, // Select enable
  input wire logic sync_serial_select_out,    // Select level
  input wire logic [7:0] timer2_out_en, // Timer enables
  input wire logic [7:0] timer2_out,    // Timer levels
  input wire logic [7:0] timer3_out_en, // Timer enables
  input wire logic [7:0] timer3_out,    // Timer levels
  input wire logic [7:0] pattern_out_en, // Pattern enables
  input wire logic [7:0] pattern_out,   // Pattern levels
  input wire logic [7:0] port1_out,     // Port 1 level
  input wire logic [7:0] port1_oe,      // Port 1 enable
  input wire logic [7:0] port2_out,     // Port 2 level
  input wire logic [7:0] port2_oe,      // Port 2 enable
  input wire logic [7:0] port3_out,     // Port 3 level
  input wire logic [7:0] port3_oe       // Port 3 enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // A read of a direction register
  sequence dir_rd_s;
    reg_rd && reg_addr < 4'h4;
  endsequence
  p1_clock_a: assert property (serial_clock_out_en |=>
    port1_oe[6] && port1_out[6] == $past(serial_clock_out)) else $error("clock pin lost");
  p1_tx_a: assert property (serial_tx_out_en |=>
    port1_oe[4] && port1_out[4] == $past(serial_tx_out)) else $error("tx pin lost");
  p2_select_a: assert property (sync_serial_select_out_en |=>
    port2_out[1] == $past(sync_serial_select_out)) else $error("select pin lost");
  p2_timer_a: assert property (timer2_out_en[5] |=>
    port2_out[5] == $past(timer2_out[5])) else $error("port 2 timer lost");
  p3_timer_a: assert property (timer3_out_en[0] |=>
    port3_oe[0] && port3_out[0] == $past(timer3_out[0])) else $error("port 3 timer lost");
  p3_pattern_a: assert property (!timer3_out_en[2] && pattern_out_en[2] |=>
    port3_oe[2] && port3_out[2] == $past(pattern_out[2])) else $error("pattern lost");
  dir_hidden_a: assert property (dir_rd_s |=> reg_rdata == 8'h00)
    else $error("direction read leaked");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=>
    (port1_oe | port2_oe | port3_oe) == 8'h00) else $error("driver on in reset");
endmodule
bind pom_top pom_monitor pom_monitor_inst (.clk, .nrst, .reg_addr, .reg_rd, .reg_rdata,
  .serial_clock_out_en, .serial_clock_out, .serial_tx_out_en, .serial_tx_out,
  .sync_serial_select_out_en, .sync_serial_select_out, .timer2_out_en, .timer2_out,
  .timer3_out_en, .timer3_out, .pattern_out_en, .pattern_out, .port1_out, .port1_oe,
  .port2_out, .port2_oe, .port3_out, .port3_oe);

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the output priority mux
// Assumes: Pins follow enables and registers two edges after a write
// Notes: Random traffic from a fixed seed plus hand corners
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  import pom_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, trig = 1'h1, loc;
  logic sce = 1'h0, sc = 1'h0, ste = 1'h0, st = 1'h0, sse = 1'h0, ss = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, ph = 8'h00, v, a, b, od;
  logic [7:0] t2e = 8'h00, t2 = 8'h00, t3e = 8'h00, t3 = 8'h00, pe = 8'h00, pv = 8'h00;
  logic [7:0] p1o, p1e, p2o, p2e, p3o, p3e, p1i, p2i, p3i, dr[3], dt[3], pho, phe;
  int n_errors = 0, tests_run = 0;
  pom_top pom_top_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_out_en(sce),
    .serial_clock_out(sc), .serial_tx_out_en(ste), .serial_tx_out(st),
    .sync_serial_select_out_en(sse), .sync_serial_select_out(ss), .timer2_out_en(t2e),
    .timer2_out(t2), .timer3_out_en(t3e), .timer3_out(t3), .pattern_out_en(pe),
    .pattern_out(pv), .port1_in(p1i), .port2_in(p2i), .port3_in(p3i), .port_h_in(ph),
    .snapshot_trigger_pin(trig), .port1_out(p1o), .port1_oe(p1e), .port2_out(p2o),
    .port2_oe(p2e), .port3_out(p3o), .port3_oe(p3e), .port_h_out(pho), .port_h_oe(phe),
    .pin_location_b(loc));
  pom_board brd1 (.clk(clk), .drv(p1o), .en(p1e), .lvl(p1i));
  pom_board brd2 (.clk(clk), .drv(p2o), .en(p2e), .lvl(p2i));
  pom_board brd3 (.clk(clk), .drv(p3o), .en(p3e), .lvl(p3i));
  // Clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  // Expected {driven, level}: higher enable first, then the direction bit
  function automatic logic [15:0] pick(input logic [7:0] he, hv, le, lv, dir, dat);
    logic [7:0] e;
    e = he | le;
    return {e | dir, (he & hv) | (~he & le & lv) | (~e & dat)};
  endfunction
  // Open drain only ever releases a driven high
  task automatic cmp(input string n, input logic [15:0] x, input logic [7:0] o, e, m);
    `CHK(n, x[15:8] & ~(m & x[7:0]), e)
    `CHK(n, x[7:0] & x[15:8], o & x[15:8])
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1; reg_addr <= ad; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'h1; reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(55));
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    #1 `CHK("reset oe", 8'h00, p1e | p2e | p3e | phe)
    rd(POM_A_ODSEL, v); `CHK("odsel rst", POM_RST8, v)
    rd(POM_A_SNAP, v); `CHK("snap rst", POM_RST8, v)
    wr(POM_A_P2_DIR, 8'hFF); rd(POM_A_P2_DIR, v); `CHK("dir read", 8'h00, v)
    wr(POM_A_SNAP, 8'hFF); rd(POM_A_SNAP, v); `CHK("snap ro", 8'h00, v)
    rd(4'hF, v); `CHK("unmapped", POM_UNMAPPED, v)
    od = 8'($urandom); wr(POM_A_ODSEL, od); rd(POM_A_ODSEL, v); `CHK("odsel rw", od, v)
    wr(POM_A_LOCSEL, 8'h01); @(posedge clk);
    #1 `CHK("location", 1'h1, loc)
    // Data read back, pin status of outputs, and port H driven from its own registers
    for (int k = 0; k < 4; k++) begin
      a = 8'($urandom); b = 8'($urandom);
      wr(POM_A_P1_DIR, 8'hFF); wr(POM_A_P1_DATA, a);
      wr(POM_A_PH_DIR, b); wr(POM_A_PH_DATA, a);
      rd(POM_A_P1_DATA, v); `CHK("data rw", a, v)
      rd(POM_A_PIN1, v); `CHK("pin status", a, v)
      `CHK("port h oe", b, phe)
      `CHK("port h out", a & b, pho & b)
    end
    $display("test registers done");
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      {sce, sc, ste, st, sse, ss} <= (i == 0) ? 6'h3F : 6'($urandom);
      t2e <= (i == 0) ? 8'hFF : 8'($urandom & $urandom); t2 <= 8'($urandom);
      t3e <= 8'($urandom & $urandom); t3 <= 8'($urandom);
      pe <= (i == 0) ? 8'hFF : 8'($urandom); pv <= 8'($urandom);
      for (int p = 0; p < 3; p++) begin
        dr[p] = 8'($urandom); dt[p] = 8'($urandom);
        wr(4'(p), dr[p]); wr(4'(p + 4), dt[p]);
      end
      od = 8'($urandom); wr(POM_A_ODSEL, od);
      repeat (2) @(posedge clk);
      #1 cmp("port1", pick({1'h0, sce, 1'h0, ste, 4'h0}, {1'h0, sc, 1'h0, st, 4'h0},
        8'h00, 8'h00, dr[0], dt[0]), p1o, p1e, 8'h00);
      cmp("port2", pick({6'h0, sse, 1'h0}, {6'h0, ss, 1'h0}, t2e, t2, dr[1], dt[1]),
        p2o, p2e, od);
      cmp("port3", pick(t3e, t3, pe, pv, dr[2], dt[2]), p3o, p3e, 8'h00);
    end
    $display("test priority done");
    // Every sense code: pin low for one cycle, then high again
    for (int s = 0; s < 4; s++) begin
      wr(POM_A_SENSE, 8'(s));
      a = 8'($urandom); b = 8'($urandom);
      @(posedge clk); trig <= 1'h0; ph <= a;
      @(posedge clk); trig <= 1'h1; ph <= b;
      @(posedge clk); ph <= ~b;
      rd(POM_A_SNAP, v); `CHK("snapshot", (s > 1) ? b : a, v)
    end
    $display("test snapshot done");
    // Reset again in mid-run: registers written above must fall back
    @(posedge clk); nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    #1 `CHK("rerun oe", 8'h00, p1e | p2e | p3e | phe)
    rd(POM_A_ODSEL, v); `CHK("odsel rerun", POM_RST8, v)
    rd(POM_A_SNAP, v); `CHK("snap rerun", POM_RST8, v)
    $display("test reset done");
    wrap_up;
  end
  // Watchdog sized well beyond the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
endmodule
